// ==== design/faceplate_indicator_controller.sv ====
// Faceplate lamp controller with Wishbone register slave
// Contract
// - Lamp test starts from faceplate button or management command.
// - During lamp test every port lamp lights together for seconds.
// - Fail lamp steady in reset or fail mode, flashing booting or writing.
// - Role lamp green when active controller, amber when standby.
// - Card lamps blink while active card writes own or standby database.
// - Severe, serious red and minor yellow lamps follow local alarms.
// - Far-end lamp red when any remote terminal reports an alarm.
// - Timing-lock lamp green only when locked to external reference.
// - Cut-off button opens audible contact and lights cut-off lamp.
// - New alarm during cut-off ends cut-off, audible alarm sounds again.
// - When causing alarm clears, cut-off lamp and audible control reset.
// - Feed lamp green while voltage lies between low and high thresholds.
// - Feed lamp red above high/extreme high or below low/extreme low.
// - Feed lamp red when its voltage measures zero.
// - Ethernet green lamp shows link, amber lamp shows receive traffic.
`default_nettype none
module faceplate_indicator_controller #(
   parameter longint TEST_CYCLES  = faceplate_pkg::TEST_CYCLES,
   parameter longint BLINK_CYCLES = faceplate_pkg::BLINK_CYCLES
) (
   input  wire  logic        clk_i,
   input  wire  logic        rst_i,
   // Wishbone classic slave
   input  wire  logic        cyc_i,
   input  wire  logic        stb_i,
   input  wire  logic        we_i,
   input  wire  logic [7:0]  adr_i,
   input  wire  logic [3:0]  sel_i,
   input  wire  logic [31:0] dat_i,
   output logic       [31:0] dat_o,
   output logic              ack_o,
   output logic              irq_o,
   // Card status inputs
   input  wire  logic        test_button_i,
   input  wire  logic        card_fail_i,
   input  wire  logic        booting_i,
   input  wire  logic        db_write_i,
   input  wire  logic        local_severe_i,
   input  wire  logic        local_serious_i,
   input  wire  logic        local_minor_i,
   input  wire  logic        remote_alarm_i,
   input  wire  logic        cutoff_button_i,
   input  wire  logic        eth_link_i,
   input  wire  logic        eth_rx_i,
   // Lamp drives
   output logic              fail_lamp_o,
   output logic [1:0]        role_lamp_o,
   output logic              severe_alarm_lamp_o,
   output logic              serious_alarm_lamp_o,
   output logic              minor_alarm_lamp_o,
   output logic              far_end_alarm_lamp_o,
   output logic              lock_lamp_o,
   output logic              cutoff_lamp_o,
   output logic              audible_contact_o,
   output logic [1:0]        feed_a_lamp_o,
   output logic [1:0]        feed_b_lamp_o,
   output logic              link_lamp_o,
   output logic              rx_traffic_lamp_o
);
   localparam int TW = 32;
   localparam int BW = 32;
   localparam logic [TW-1:0] TEST_LOAD  = TW'(TEST_CYCLES - 1);
   localparam logic [BW-1:0] BLINK_LOAD = BW'(BLINK_CYCLES - 1);

   // Software registers
   logic [2:0]  ctrl;
   logic [faceplate_pkg::EV_WIDTH-1:0] irq_stat;
   logic [faceplate_pkg::EV_WIDTH-1:0] irq_mask;
   logic [15:0] feed_a;
   logic [15:0] feed_b;
   logic [15:0] thr_lo;
   logic [15:0] thr_hi;
   logic [15:0] thr_elo;
   logic [15:0] thr_ehi;

   faceplate_pkg::alarm_set_t   alarms;
   faceplate_pkg::alarm_set_t   alarms_q;
   faceplate_pkg::test_state_t  tst;
   logic [TW-1:0] test_cnt;
   logic [BW-1:0] blink_cnt;
   logic          blink;
   logic          cutoff;
   logic          test_btn_q;
   logic          cut_btn_q;
   logic          feed_bad_q;
   logic          remote_q;
   logic          remote_rise;
   logic          wr;
   logic          rd;
   logic          test_req;
   logic          new_alarm;
   logic          any_alarm;
   logic          testing;
   logic          feed_a_ok;
   logic          feed_b_ok;
   logic          cutoff_end;
   logic [faceplate_pkg::EV_WIDTH-1:0] events;

   assign alarms    = '{severe: local_severe_i, serious: local_serious_i,
                        minor: local_minor_i};
   assign any_alarm = |alarms | remote_alarm_i;
   // New alarm is any local bit or remote bit rising
   assign remote_rise = remote_alarm_i & ~remote_q;
   assign new_alarm   = |(alarms & ~alarms_q) | remote_rise;
   assign wr = cyc_i & stb_i & we_i & ack_o;    // Write lands on the acked edge
   assign rd = cyc_i & stb_i & ~we_i & ~ack_o;  // Read data stands by the acked edge
   assign testing = (tst == faceplate_pkg::TST_RUN);

   // Test request from button edge or write of the test bit
   assign test_req = (test_button_i & ~test_btn_q)
                   | (wr & adr_i == faceplate_pkg::CTRL_OFS & sel_i[0]
                      & dat_i[faceplate_pkg::CTRL_TEST_BIT]);

   // Feed windows: zero and any out-of-window value reads as bad
   assign feed_a_ok = (feed_a != 16'h0000) & (feed_a >= thr_lo) & (feed_a <= thr_hi)
                    & (feed_a >= thr_elo) & (feed_a <= thr_ehi);
   assign feed_b_ok = (feed_b != 16'h0000) & (feed_b >= thr_lo) & (feed_b <= thr_hi)
                    & (feed_b >= thr_elo) & (feed_b <= thr_ehi);

   assign cutoff_end = cutoff & (new_alarm | ~any_alarm);
   assign events = {tst == faceplate_pkg::TST_DONE,
                    (~feed_a_ok | ~feed_b_ok) & ~feed_bad_q,
                    cutoff_end,
                    new_alarm};

   // Input edge history
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         alarms_q   <= '0;
         remote_q   <= 1'b0;
         test_btn_q <= 1'b0;
         cut_btn_q  <= 1'b0;
         feed_bad_q <= 1'b1;   // Feeds reset to zero, so already bad
      end
      else
      begin
         alarms_q   <= alarms;
         remote_q   <= remote_alarm_i;
         test_btn_q <= test_button_i;
         cut_btn_q  <= cutoff_button_i;
         feed_bad_q <= ~feed_a_ok | ~feed_b_ok;
      end
   end

   // Shared blink divider keeps every blinking lamp in phase
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         blink_cnt <= BLINK_LOAD;
         blink     <= 1'b0;
      end
      else if (blink_cnt == '0)
      begin
         blink_cnt <= BLINK_LOAD;
         blink     <= ~blink;
      end
      else
         blink_cnt <= blink_cnt - 1'b1;
   end

   // Lamp test sequencer; a retrigger restarts the count
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tst      <= faceplate_pkg::TST_IDLE;
         test_cnt <= '0;
      end
      else
      begin
         case (tst)
            faceplate_pkg::TST_IDLE:
               if (test_req)
               begin
                  tst      <= faceplate_pkg::TST_RUN;
                  test_cnt <= TEST_LOAD;
               end
            faceplate_pkg::TST_RUN:
               if (test_req)
                  test_cnt <= TEST_LOAD;
               else if (test_cnt == '0)
                  tst <= faceplate_pkg::TST_DONE;
               else
                  test_cnt <= test_cnt - 1'b1;
            faceplate_pkg::TST_DONE:
               tst <= faceplate_pkg::TST_IDLE;
            default:
               tst <= faceplate_pkg::TST_IDLE;
         endcase
      end
   end

   // Cut-off latch: set by button, ended by new alarm or alarm clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cutoff <= 1'b0;
      else if (cutoff_end)
         cutoff <= 1'b0;
      else if (cutoff_button_i & ~cut_btn_q & any_alarm)
         cutoff <= 1'b1;
   end

   // Register writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl     <= 3'h0;
         irq_mask <= '0;
         feed_a   <= 16'h0000;
         feed_b   <= 16'h0000;
         thr_lo   <= faceplate_pkg::THR_LO_RST;
         thr_hi   <= faceplate_pkg::THR_HI_RST;
         thr_elo  <= faceplate_pkg::THR_ELO_RST;
         thr_ehi  <= faceplate_pkg::THR_EHI_RST;
      end
      else if (wr & sel_i[0])
      begin
         case (adr_i)
            faceplate_pkg::CTRL_OFS:    ctrl     <= {dat_i[2:1], 1'b0};
            faceplate_pkg::MASK_OFS:    irq_mask <= dat_i[faceplate_pkg::EV_WIDTH-1:0];
            faceplate_pkg::FEED_A_OFS:  feed_a[7:0]  <= dat_i[7:0];
            faceplate_pkg::FEED_B_OFS:  feed_b[7:0]  <= dat_i[7:0];
            faceplate_pkg::THR_LO_OFS:  thr_lo[7:0]  <= dat_i[7:0];
            faceplate_pkg::THR_HI_OFS:  thr_hi[7:0]  <= dat_i[7:0];
            faceplate_pkg::THR_ELO_OFS: thr_elo[7:0] <= dat_i[7:0];
            faceplate_pkg::THR_EHI_OFS: thr_ehi[7:0] <= dat_i[7:0];
            default: ;
         endcase
         if (sel_i[1])
         begin
            case (adr_i)
               faceplate_pkg::FEED_A_OFS:  feed_a[15:8]  <= dat_i[15:8];
               faceplate_pkg::FEED_B_OFS:  feed_b[15:8]  <= dat_i[15:8];
               faceplate_pkg::THR_LO_OFS:  thr_lo[15:8]  <= dat_i[15:8];
               faceplate_pkg::THR_HI_OFS:  thr_hi[15:8]  <= dat_i[15:8];
               faceplate_pkg::THR_ELO_OFS: thr_elo[15:8] <= dat_i[15:8];
               faceplate_pkg::THR_EHI_OFS: thr_ehi[15:8] <= dat_i[15:8];
               default: ;
            endcase
         end
      end
   end

   // Sticky events; a set in the clearing cycle wins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_stat <= '0;
      else if (wr & sel_i[0] & adr_i == faceplate_pkg::IRQ_OFS)
         irq_stat <= (irq_stat & ~dat_i[faceplate_pkg::EV_WIDTH-1:0]) | events;
      else
         irq_stat <= irq_stat | events;
   end

   // Bus answer: one-cycle ack, unmapped reads zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         irq_o <= 1'b0;
      end
      else
      begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         irq_o <= |((irq_stat | events) & irq_mask);
         if (rd)
         begin
            case (adr_i)
               faceplate_pkg::CTRL_OFS:    dat_o <= {29'h0, ctrl[2:1], testing};
               faceplate_pkg::STATUS_OFS:  dat_o <= {24'h0, cutoff, feed_b_ok, feed_a_ok,
                                                     remote_alarm_i, alarms, testing};
               faceplate_pkg::IRQ_OFS:     dat_o <= {28'h0, irq_stat};
               faceplate_pkg::MASK_OFS:    dat_o <= {28'h0, irq_mask};
               faceplate_pkg::FEED_A_OFS:  dat_o <= {16'h0, feed_a};
               faceplate_pkg::FEED_B_OFS:  dat_o <= {16'h0, feed_b};
               faceplate_pkg::THR_LO_OFS:  dat_o <= {16'h0, thr_lo};
               faceplate_pkg::THR_HI_OFS:  dat_o <= {16'h0, thr_hi};
               faceplate_pkg::THR_ELO_OFS: dat_o <= {16'h0, thr_elo};
               faceplate_pkg::THR_EHI_OFS: dat_o <= {16'h0, thr_ehi};
               faceplate_pkg::LAMPS_OFS:   dat_o <= {22'h0, feed_b_lamp_o, feed_a_lamp_o,
                                                     role_lamp_o, cutoff_lamp_o,
                                                     lock_lamp_o, fail_lamp_o, audible_contact_o};
               default:                    dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Lamp drives; lamp test overrides all lamps but not the audible contact, card lamps blink on active-card writes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fail_lamp_o          <= 1'b1;
         role_lamp_o          <= faceplate_pkg::LAMP_OFF;
         severe_alarm_lamp_o  <= 1'b0;
         serious_alarm_lamp_o <= 1'b0;
         minor_alarm_lamp_o   <= 1'b0;
         far_end_alarm_lamp_o <= 1'b0;
         lock_lamp_o          <= 1'b0;
         cutoff_lamp_o        <= 1'b0;
         audible_contact_o    <= 1'b0;
         feed_a_lamp_o        <= faceplate_pkg::LAMP_OFF;
         feed_b_lamp_o        <= faceplate_pkg::LAMP_OFF;
         link_lamp_o          <= 1'b0;
         rx_traffic_lamp_o    <= 1'b0;
      end
      else if (testing)
      begin
         fail_lamp_o          <= 1'b1;
         role_lamp_o          <= faceplate_pkg::LAMP_AMBER;
         severe_alarm_lamp_o  <= 1'b1;
         serious_alarm_lamp_o <= 1'b1;
         minor_alarm_lamp_o   <= 1'b1;
         far_end_alarm_lamp_o <= 1'b1;
         lock_lamp_o          <= 1'b1;
         cutoff_lamp_o        <= 1'b1;
         audible_contact_o    <= any_alarm & ~cutoff;
         feed_a_lamp_o        <= faceplate_pkg::LAMP_AMBER;
         feed_b_lamp_o        <= faceplate_pkg::LAMP_AMBER;
         link_lamp_o          <= 1'b1;
         rx_traffic_lamp_o    <= 1'b1;
      end
      else
      begin
         fail_lamp_o <= card_fail_i | ((booting_i | db_write_i) & blink);
         if (db_write_i & ctrl[faceplate_pkg::CTRL_ACTIVE_BIT] & ~blink)
            role_lamp_o <= faceplate_pkg::LAMP_OFF;
         else
            role_lamp_o <= ctrl[faceplate_pkg::CTRL_ACTIVE_BIT] ?
                           faceplate_pkg::LAMP_GREEN : faceplate_pkg::LAMP_AMBER;
         severe_alarm_lamp_o  <= alarms.severe;
         serious_alarm_lamp_o <= alarms.serious;
         minor_alarm_lamp_o   <= alarms.minor;
         far_end_alarm_lamp_o <= remote_alarm_i;
         lock_lamp_o          <= ctrl[faceplate_pkg::CTRL_LOCK_BIT];
         cutoff_lamp_o        <= cutoff & ~cutoff_end;
         audible_contact_o    <= any_alarm & ~(cutoff & ~cutoff_end);
         feed_a_lamp_o <= feed_a_ok ? faceplate_pkg::LAMP_GREEN : faceplate_pkg::LAMP_RED;
         feed_b_lamp_o <= feed_b_ok ? faceplate_pkg::LAMP_GREEN : faceplate_pkg::LAMP_RED;
         link_lamp_o          <= eth_link_i;
         rx_traffic_lamp_o    <= eth_rx_i;
      end
   end

   // Checks; lamps still hold reset values one edge past the release edge
   test_lamps_a: assert property (@(posedge clk_i) disable iff (rst_i)
      testing |=> severe_alarm_lamp_o && link_lamp_o) else $error("lamp test not lit");
   test_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (tst == faceplate_pkg::TST_IDLE && test_req) |=> testing)
      else $error("lamp test not started");
   test_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (testing && test_cnt == '0 && !test_req) |=> tst == faceplate_pkg::TST_DONE)
      else $error("lamp test did not end");
   fail_steady_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (card_fail_i && !testing) |=> fail_lamp_o) else $error("fail lamp not on");
   role_colour_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rst_i && !testing && !db_write_i && !ctrl[faceplate_pkg::CTRL_ACTIVE_BIT])
      |=> role_lamp_o == faceplate_pkg::LAMP_AMBER) else $error("standby not amber");
   alarm_lamps_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rst_i && !testing) |=> severe_alarm_lamp_o == $past(local_severe_i)
                   && far_end_alarm_lamp_o == $past(remote_alarm_i))
      else $error("alarm lamp mismatch");
   lock_lamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!testing && !ctrl[2]) |=> !lock_lamp_o) else $error("lock lamp wrongly lit");
   cutoff_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cutoff && new_alarm) |=> !cutoff) else $error("cut-off survived new alarm");
   cutoff_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cutoff && !any_alarm) |=> !cutoff) else $error("cut-off survived clear");
   feed_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rst_i && !testing && feed_a == 16'h0000) |=> feed_a_lamp_o == faceplate_pkg::LAMP_RED)
      else $error("zero feed not red");
   blink_phase_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (blink_cnt == '0) |=> blink != $past(blink)) else $error("blink not toggled");
   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held");
   test_run_c:   cover property (@(posedge clk_i) tst == faceplate_pkg::TST_DONE);
   cutoff_on_c:  cover property (@(posedge clk_i) cutoff_lamp_o);
   cutoff_end_c: cover property (@(posedge clk_i) cutoff && new_alarm);
   feed_good_c:  cover property (@(posedge clk_i) feed_a_lamp_o == faceplate_pkg::LAMP_GREEN);
endmodule // faceplate_indicator_controller
`default_nettype wire

// ==== design/faceplate_pkg.sv ====
// Package: constants, register map and carrier structs for the faceplate lamp controller
`default_nettype none
package faceplate_pkg;
   // Wishbone register byte offsets
   localparam logic [7:0] CTRL_OFS    = 8'h00;
   localparam logic [7:0] STATUS_OFS  = 8'h04;
   localparam logic [7:0] IRQ_OFS     = 8'h08;
   localparam logic [7:0] MASK_OFS    = 8'h0C;
   localparam logic [7:0] FEED_A_OFS  = 8'h10;
   localparam logic [7:0] FEED_B_OFS  = 8'h14;
   localparam logic [7:0] THR_LO_OFS  = 8'h18;
   localparam logic [7:0] THR_HI_OFS  = 8'h1C;
   localparam logic [7:0] THR_ELO_OFS = 8'h20;
   localparam logic [7:0] THR_EHI_OFS = 8'h24;
   localparam logic [7:0] LAMPS_OFS   = 8'h28;
   // Control register fields
   localparam int CTRL_TEST_BIT    = 0;
   localparam int CTRL_ACTIVE_BIT  = 1;
   localparam int CTRL_LOCK_BIT    = 2;
   // Interrupt event bit positions
   localparam int EV_NEW_ALARM  = 0;
   localparam int EV_CUTOFF_END = 1;
   localparam int EV_FEED_BAD   = 2;
   localparam int EV_TEST_DONE  = 3;
   localparam int EV_WIDTH      = 4;
   // Feed voltage width and threshold reset values
   localparam int          VOLT_W       = 16;
   localparam logic [15:0] THR_LO_RST   = 16'h0100;
   localparam logic [15:0] THR_HI_RST   = 16'h0F00;
   localparam logic [15:0] THR_ELO_RST  = 16'h0080;
   localparam logic [15:0] THR_EHI_RST  = 16'h0F80;
   // Timing: clock, lamp test length, blink half period
   localparam longint CLK_HZ        = 20000000;
   localparam longint TEST_MS       = 3000;
   localparam longint BLINK_MS      = 250;
   localparam longint TEST_CYCLES   = (CLK_HZ / 1000) * TEST_MS;
   localparam longint BLINK_CYCLES  = (CLK_HZ / 1000) * BLINK_MS;
   // Two-colour lamp encodings
   typedef enum logic [1:0] {
      LAMP_OFF   = 2'h0,
      LAMP_GREEN = 2'h1,
      LAMP_RED   = 2'h2,
      LAMP_AMBER = 2'h3
   } lamp_colour_t;
   // Alarm severity bundle
   typedef struct packed {
      logic severe;
      logic serious;
      logic minor;
   } alarm_set_t;
   // Test sequencer states (one-bit steps from IDLE to RUN to DONE)
   typedef enum logic [1:0] {
      TST_IDLE = 2'h0,
      TST_RUN  = 2'h1,
      TST_DONE = 2'h3
   } test_state_t;
endpackage
`default_nettype wire

// ==== verif/faceplate_indicator_controller_test.sv ====
// Self-checking bench for the faceplate lamp controller
`default_nettype none
module faceplate_indicator_controller_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        test_btn = 1'b0, card_fail = 1'b0, booting = 1'b0, db_write = 1'b0;
   logic        sev = 1'b0, ser = 1'b0, mnr = 1'b0, far_end_alarm_lamp = 1'b0, aco_btn = 1'b0;
   logic        link = 1'b0, rx = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dat;
   logic        ack, irq, fail_l, sev_l, ser_l, mnr_l, rem_l, lock_l, aco_l, horn, link_l, rx_l;
   logic [1:0]  role_l, feed_a, feed_b;
   int          num_errors = 0, total_checks = 0;
   wire  [7:0]  singles = {sev_l, ser_l, mnr_l, rem_l, lock_l, aco_l, link_l, rx_l};

   // Short test and blink counts keep the run brief
   faceplate_indicator_controller #(.TEST_CYCLES(20), .BLINK_CYCLES(4)) dut (
      .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(dat), .ack_o(ack), .irq_o(irq),
      .test_button_i(test_btn), .card_fail_i(card_fail), .booting_i(booting),
      .db_write_i(db_write), .local_severe_i(sev), .local_serious_i(ser),
      .local_minor_i(mnr), .remote_alarm_i(far_end_alarm_lamp), .cutoff_button_i(aco_btn),
      .eth_link_i(link), .eth_rx_i(rx), .fail_lamp_o(fail_l), .role_lamp_o(role_l),
      .severe_alarm_lamp_o(sev_l), .serious_alarm_lamp_o(ser_l),
      .minor_alarm_lamp_o(mnr_l), .far_end_alarm_lamp_o(rem_l), .lock_lamp_o(lock_l),
      .cutoff_lamp_o(aco_l), .audible_contact_o(horn), .feed_a_lamp_o(feed_a),
      .feed_b_lamp_o(feed_b), .link_lamp_o(link_l), .rx_traffic_lamp_o(rx_l)
   );

   // 20 MHz system clock
   always #25 clk = ~clk;

   // Compare and tally
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Counts, verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One classic cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20)
      begin
         num_errors++;
         close_out();
      end
   endtask

   // Let registered lamps follow, then sample mid-cycle
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Main sequence
   initial
   begin
      int chg_r, chg_f, hi, i;
      logic [1:0] pr;
      logic pf;
      logic [15:0] fv [6] = '{16'h0000, 16'h0100, 16'h00FF, 16'h0F00, 16'h0F01, 16'h0800};
      logic [1:0] fe [6] = '{2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
      repeat (9) @(posedge clk);
      @(negedge clk);
      check("reset outputs", {fail_l, role_l, feed_a, feed_b, singles, horn, ack, irq}, 32'h20000);
      @(posedge clk);
      rst <= 1'b0;
      $display("test reset done");
      wb(1'b1, faceplate_pkg::CTRL_OFS, 32'h6);
      settle(2);
      check("role active", role_l, faceplate_pkg::LAMP_GREEN);
      check("lock on", lock_l, 32'h1);
      wb(1'b1, faceplate_pkg::CTRL_OFS, 32'h0);
      settle(2);
      check("role standby", role_l, faceplate_pkg::LAMP_AMBER);
      check("lock off", lock_l, 32'h0);
      $display("test role done");
      // Both blinking lamps share one divider, so edge counts agree
      wb(1'b1, faceplate_pkg::CTRL_OFS, 32'h2);
      @(posedge clk);
      db_write <= 1'b1;
      booting <= 1'b1;
      settle(2);
      chg_r = 0;
      chg_f = 0;
      pr = role_l;
      pf = fail_l;
      repeat (24)
      begin
         @(negedge clk);
         chg_r += (role_l !== pr);
         chg_f += (fail_l !== pf);
         pr = role_l;
         pf = fail_l;
         check("role colour", role_l[1], 32'h0);
      end
      check("role blinks", (chg_r >= 4 && chg_r <= 7), 32'h1);
      check("fail flashes", chg_f, chg_r);
      @(posedge clk);
      db_write <= 1'b0;
      booting <= 1'b0;
      card_fail <= 1'b1;
      settle(2);
      hi = 0;
      repeat (12)
      begin
         @(negedge clk);
         hi += (fail_l === 1'b1);
      end
      check("fail steady", hi, 32'd12);
      @(posedge clk);
      card_fail <= 1'b0;
      settle(2);
      check("fail clear", {fail_l, role_l}, 32'h1);
      $display("test blink done");
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         {sev, ser, mnr, far_end_alarm_lamp} <= 4'h8 >> i;
         settle(2);
         check("alarm lamps", singles[7:4], 32'h8 >> i);
      end
      @(posedge clk);
      far_end_alarm_lamp <= 1'b0;
      sev <= 1'b1;
      settle(2);
      check("horn on", {aco_l, horn}, 32'h1);
      for (i = 0; i < 3; i++)
      begin
         // Cut-off only latches while an alarm stands
         @(posedge clk);
         sev <= 1'b1;
         @(posedge clk);
         aco_btn <= 1'b1;
         @(posedge clk);
         aco_btn <= 1'b0;
         settle(2);
         check("cut-off set", {aco_l, horn}, 32'h2);
         @(posedge clk);
         if (i == 0)
            ser <= 1'b1;
         else if (i == 1)
            {sev, ser} <= 2'b00;
         else
            far_end_alarm_lamp <= 1'b1;
         settle(2);
         check("cut-off end", {aco_l, horn}, (i == 1) ? 32'h0 : 32'h1);
      end
      @(posedge clk);
      sev <= 1'b0;
      far_end_alarm_lamp <= 1'b0;
      $display("test cut-off done");
      wb(1'b0, faceplate_pkg::IRQ_OFS, 32'h0);
      check("events", rdat & 32'h3, 32'h3);
      check("irq masked", irq, 32'h0);
      wb(1'b1, faceplate_pkg::MASK_OFS, 32'h2);
      settle(1);
      check("irq raised", irq, 32'h1);
      wb(1'b1, faceplate_pkg::IRQ_OFS, 32'h2);
      settle(1);
      check("irq cleared", irq, 32'h0);
      $display("test irq done");
      for (i = 0; i < 6; i++)
      begin
         wb(1'b1, faceplate_pkg::FEED_A_OFS, {16'h0, fv[i]});
         wb(1'b1, faceplate_pkg::FEED_B_OFS, {16'h0, fv[(i + 1) % 6]});
         settle(2);
         check("feed a", feed_a, fe[i]);
         check("feed b", feed_b, fe[(i + 1) % 6]);
      end
      // Low bound below extreme low, so extreme low decides
      wb(1'b1, faceplate_pkg::THR_LO_OFS, 32'h50);
      wb(1'b1, faceplate_pkg::FEED_A_OFS, 32'h60);
      settle(2);
      check("feed extreme low", feed_a, faceplate_pkg::LAMP_RED);
      wb(1'b1, faceplate_pkg::FEED_A_OFS, 32'h80);
      settle(2);
      check("feed edge", feed_a, faceplate_pkg::LAMP_GREEN);
      $display("test feed done");
      @(posedge clk);
      link <= 1'b1;
      settle(2);
      check("link", {link_l, rx_l}, 32'h2);
      @(posedge clk);
      {link, rx} <= 2'b01;
      settle(2);
      check("rx", {link_l, rx_l}, 32'h1);
      @(posedge clk);
      rx <= 1'b0;
      $display("test ethernet done");
      for (i = 0; i < 2; i++)
      begin
         if (i == 0)
            wb(1'b1, faceplate_pkg::CTRL_OFS, 32'h3);
         else
         begin
            @(posedge clk);
            test_btn <= 1'b1;
            @(posedge clk);
            test_btn <= 1'b0;
         end
         hi = 0;
         repeat (40)
         begin
            @(negedge clk);
            hi += (singles === 8'hFF && feed_a === 2'h3 && role_l === 2'h3);
         end
         check("test length", hi, 32'd20);
         check("after test", singles, 32'h0);
         wb(1'b0, faceplate_pkg::IRQ_OFS, 32'h0);
         check("test done event", rdat[3], 32'h1);
         wb(1'b1, faceplate_pkg::IRQ_OFS, 32'h8);
      end
      $display("test lamp test done");
      wb(1'b0, faceplate_pkg::STATUS_OFS, 32'h0);
      check("status", rdat, 32'h20);
      wb(1'b0, 8'h30, 32'h0);
      check("unmapped", rdat, 32'h0);
      $display("test registers done");
      close_out();
   end
endmodule // faceplate_indicator_controller_test
`default_nettype wire
